// ==== hdl/osc_defs.svh ====
// Constants for the octal switch channel control block.
`ifndef OSC_DEFS_SVH
`define OSC_DEFS_SVH

`define OSC_CH_COUNT 8
`define OSC_FRAME_BITS 16
`define OSC_CNT_BITS 5
`define OSC_PIN_BITS 31

`define OSC_MAP0_RESET 8'h04
`define OSC_MAP1_RESET 8'h08
`define OSC_OUT_RESET 8'h00
`define OSC_PROBE_RESET 8'h00
`define OSC_FS_CH_A 2
`define OSC_FS_CH_B 3
`define OSC_FS_MASK 8'h0C

`define OSC_SPI_OUT 3'h0
`define OSC_SPI_MAP0 3'h1
`define OSC_SPI_MAP1 3'h2
`define OSC_SPI_PROBE 3'h3
`define OSC_SPI_CLEAR 3'h4

`define OSC_APB_STATUS 12'h000
`define OSC_APB_CLEAR 12'h004
`define OSC_APB_ENABLE 12'h008
`define OSC_APB_CHANNEL 12'h00C
`define OSC_APB_CONFIG 12'h010

`define OSC_IRQ_BITS 3
`define OSC_IRQ_FRAME 0
`define OSC_IRQ_FAULT 1
`define OSC_IRQ_FAILSAFE 2

`define OSC_RESTART_TIME_US 1000
`define OSC_PCLK_MHZ 40

`endif

// ==== hdl/osc_pkg.sv ====
// Types shared by the octal switch channel control block.
package osc_pkg;

    typedef struct packed {
        logic write;
        logic [2:0] addr;
        logic [3:0] spare;
        logic [7:0] data;
    } osc_frame_type;

    typedef struct packed {
        logic [7:0] thermal;
        logic [7:0] overload;
        logic [7:0] monitor;
        logic [7:0] drive;
    } osc_channel_view_type;

    typedef enum logic [1:0] {
        OSC_IDLE = 2'b00,
        OSC_SHIFT = 2'b01,
        OSC_DONE = 2'b11
    } osc_spi_state_type;

endpackage : osc_pkg

// ==== hdl/osc_retry_timer.sv ====
// Restart timer for one channel in fail-safe operation.
`timescale 1ns/1ps
`include "osc_defs.svh"

module osc_retry_timer #(
    parameter int unsigned CYCLES = `OSC_RESTART_TIME_US * `OSC_PCLK_MHZ
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    output logic expire
);
    import osc_pkg::*;

    logic [31:0] count;

    // The count restarts whenever the wait condition drops, so a brief input low re-arms it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= 32'h00000000;
            expire <= 1'b0;
        end else if (!run) begin
            count <= 32'h00000000;
            expire <= 1'b0;
        end else if (count == 32'(CYCLES - 1)) begin
            count <= 32'h00000000;
            expire <= 1'b1;
        end else begin
            count <= count + 32'h00000001;
            expire <= 1'b0;
        end
    end

endmodule : osc_retry_timer

// ==== hdl/osc_spi_port.sv ====
// Sixteen-bit daisy-chainable serial port, oversampled by the system clock.
`timescale 1ns/1ps
`include "osc_defs.svh"

module osc_spi_port (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic enable,
    input wire logic sclk,
    input wire logic chip_select_n,
    input wire logic serial_in,
    input wire logic [`OSC_FRAME_BITS-1:0] tx_word,
    output osc_pkg::osc_frame_type rx_frame,
    output logic rx_valid,
    output logic serial_out,
    output logic serial_out_oe
);
    import osc_pkg::*;

    osc_spi_state_type state;
    logic sclk_d;
    logic [`OSC_FRAME_BITS-1:0] shift;
    logic [`OSC_CNT_BITS-1:0] count;
    logic rise;
    logic fall;

    assign rise = sclk && !sclk_d;
    assign fall = !sclk && sclk_d;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sclk_d <= 1'b0;
        end else begin
            sclk_d <= sclk;
        end
    end

    // Bits pass straight through the shift register, so any chain length of sixteen bits or more works and
    // the last sixteen bits seen before deselect form the frame.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= OSC_IDLE;
            shift <= 16'h0000;
            count <= 5'h00;
            serial_out <= 1'b0;
            serial_out_oe <= 1'b0;
            rx_valid <= 1'b0;
            rx_frame <= 16'h0000;
        end else if (!enable) begin
            state <= OSC_IDLE;
            serial_out_oe <= 1'b0;
            rx_valid <= 1'b0;
        end else begin
            rx_valid <= 1'b0;
            case (state)
                OSC_IDLE: begin
                    serial_out_oe <= 1'b0;
                    if (!chip_select_n) begin
                        shift <= tx_word;
                        serial_out <= tx_word[`OSC_FRAME_BITS-1];
                        serial_out_oe <= 1'b1;
                        count <= 5'h00;
                        state <= OSC_SHIFT;
                    end
                end
                OSC_SHIFT: begin
                    if (chip_select_n) begin
                        serial_out_oe <= 1'b0;
                        state <= OSC_DONE;
                    end else if (rise) begin
                        shift <= {shift[`OSC_FRAME_BITS-2:0], serial_in};
                        if (count != 5'(`OSC_FRAME_BITS)) begin
                            count <= count + 5'h01;
                        end
                    end else if (fall) begin
                        serial_out <= shift[`OSC_FRAME_BITS-1];
                    end
                end
                OSC_DONE: begin
                    // Short frames are dropped rather than acted on half-filled.
                    if (count == 5'(`OSC_FRAME_BITS)) begin
                        rx_frame <= shift;
                        rx_valid <= 1'b1;
                    end
                    state <= OSC_IDLE;
                end
                default: begin
                    state <= OSC_IDLE;
                end
            endcase
        end
    end

    property p_so_released;
        @(posedge pclk) disable iff (!presetn)
        (chip_select_n || !enable) |=> !serial_out_oe;
    endproperty
    a_so_released: assert property (p_so_released) else $error("output driven while deselected");

    property p_no_access_unpowered;
        @(posedge pclk) disable iff (!presetn)
        !enable |=> !rx_valid && $stable(rx_frame);
    endproperty
    a_no_access_unpowered: assert property (p_no_access_unpowered) else $error("frame taken unpowered");

    property p_full_frame;
        @(posedge pclk) disable iff (!presetn)
        rx_valid |-> $past(count) == 5'(`OSC_FRAME_BITS) && $past(state) == OSC_DONE;
    endproperty
    a_full_frame: assert property (p_full_frame) else $error("frame shorter than sixteen bits");

endmodule : osc_spi_port

// ==== hdl/osc_switch_ctrl.sv ====
// Top of the octal switch channel control: serial port, input mapping, fault latches, APB.
//
// Register access over APB and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "osc_defs.svh"

module osc_switch_ctrl #(
    parameter int unsigned RESTART_CYCLES = `OSC_RESTART_TIME_US * `OSC_PCLK_MHZ
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    input wire logic sclk,
    input wire logic chip_select_n,
    input wire logic serial_in,
    output logic serial_out,
    output logic serial_out_oe,
    input wire logic supply_present,
    input wire logic idle_select,
    input wire logic direct_input_zero,
    input wire logic direct_input_one,
    input wire logic [`OSC_CH_COUNT-1:0] overload_detect,
    input wire logic [`OSC_CH_COUNT-1:0] overtemp_detect,
    input wire logic [`OSC_CH_COUNT-1:0] open_load_sense,
    output logic [`OSC_CH_COUNT-1:0] channel_on,
    output logic [`OSC_CH_COUNT-1:0] open_load_probe_current
);
    import osc_pkg::*;

    logic [`OSC_PIN_BITS-1:0] pins_meta;
    logic [`OSC_PIN_BITS-1:0] pins_sync;
    logic sclk_s;
    logic csn_s;
    logic si_s;
    logic vdd_s;
    logic idle_s;
    logic in0_s;
    logic in1_s;
    logic [7:0] ovl_s;
    logic [7:0] tmp_s;
    logic [7:0] output_monitor_bits;
    logic failsafe;
    logic failsafe_d;
    logic [7:0] out_ctrl;
    logic [7:0] map0;
    logic [7:0] map1;
    logic [7:0] probe_ctrl;
    logic [7:0] ovl_latch;
    logic [7:0] thr_latch;
    logic [7:0] spi_clear;
    logic [7:0] restart;
    logic [7:0] next_drive;
    logic [7:0] ovl_new;
    osc_frame_type rx_frame;
    logic rx_valid;
    logic [`OSC_FRAME_BITS-1:0] tx_word;
    logic [`OSC_IRQ_BITS-1:0] irq_status;
    logic [`OSC_IRQ_BITS-1:0] irq_enable;
    logic [`OSC_IRQ_BITS-1:0] irq_event;
    logic [`OSC_IRQ_BITS-1:0] irq_clear;
    logic apb_write;
    logic apb_setup;
    osc_channel_view_type chan_view;
    // Two flops on every pin; the 40 MHz sampling resolves serial clock edges only
    // because the controller keeps that clock at or below 5 MHz.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pins_meta <= 31'h00000000;
            pins_sync <= 31'h00000000;
        end else begin
            pins_meta <= {open_load_sense, overtemp_detect, overload_detect, direct_input_one,
                direct_input_zero, idle_select, supply_present, serial_in, chip_select_n, sclk};
            pins_sync <= pins_meta;
        end
    end

    assign sclk_s = pins_sync[0];
    assign csn_s = pins_sync[1];
    assign si_s = pins_sync[2];
    assign vdd_s = pins_sync[3];
    assign idle_s = pins_sync[4];
    assign in0_s = pins_sync[5];
    assign in1_s = pins_sync[6];
    assign ovl_s = pins_sync[14:7];
    assign tmp_s = pins_sync[22:15];
    assign output_monitor_bits = pins_sync[30:23];

    // Fail-safe mode: digital supply lost while the idle pin is low.
    assign failsafe = !vdd_s && !idle_s;

    // Answer carries the latched faults and the live monitor bits.
    assign tx_word = {ovl_latch | thr_latch, output_monitor_bits};

    osc_spi_port u_spi (
        .pclk(pclk),
        .presetn(presetn),
        .enable(vdd_s),
        .sclk(sclk_s),
        .chip_select_n(csn_s),
        .serial_in(si_s),
        .tx_word(tx_word),
        .rx_frame(rx_frame),
        .rx_valid(rx_valid),
        .serial_out(serial_out),
        .serial_out_oe(serial_out_oe)
    );

    // Serially written configuration; mappings start on the fixed default channels.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_ctrl <= `OSC_OUT_RESET;
            map0 <= `OSC_MAP0_RESET;
            map1 <= `OSC_MAP1_RESET;
            probe_ctrl <= `OSC_PROBE_RESET;
        end else if (rx_valid && rx_frame.write) begin
            case (rx_frame.addr)
                `OSC_SPI_OUT: out_ctrl <= rx_frame.data;
                `OSC_SPI_MAP0: map0 <= rx_frame.data;
                `OSC_SPI_MAP1: map1 <= rx_frame.data;
                `OSC_SPI_PROBE: probe_ctrl <= rx_frame.data;
                default: ;
            endcase
        end
    end

    assign spi_clear = (rx_valid && rx_frame.write && rx_frame.addr == `OSC_SPI_CLEAR)
        ? rx_frame.data : 8'h00;

    // One restart timer per channel, armed only by an overload in fail-safe mode.
    genvar ch;
    generate
        for (ch = 0; ch < `OSC_CH_COUNT; ch = ch + 1) begin : g_retry
            logic mapped_high;
            assign mapped_high = (ch == `OSC_FS_CH_A && in0_s) || (ch == `OSC_FS_CH_B && in1_s);
            osc_retry_timer #(
                .CYCLES(RESTART_CYCLES)
            ) u_timer (
                .pclk(pclk),
                .presetn(presetn),
                .run(failsafe && ovl_latch[ch] && !thr_latch[ch] && mapped_high),
                .expire(restart[ch])
            );
        end
    endgenerate

    assign ovl_new = ovl_s & channel_on;

    // A trip while on latches the channel off; a trip in the clear cycle still wins.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ovl_latch <= 8'h00;
        end else begin
            ovl_latch <= (ovl_latch & ~spi_clear & ~restart) | ovl_new;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            thr_latch <= 8'h00;
        end else begin
            thr_latch <= (thr_latch & ~spi_clear) | tmp_s;
        end
    end

    // Channel request: all off in idle, fixed routing in fail-safe, mapped inputs plus serial bits otherwise.
    always_comb begin
        next_drive = 8'h00;
        if (idle_s) begin
            next_drive = 8'h00;
        end else if (failsafe) begin
            next_drive[`OSC_FS_CH_A] = in0_s;
            next_drive[`OSC_FS_CH_B] = in1_s;
        end else begin
            next_drive = out_ctrl | (map0 & {8{in0_s}}) | (map1 & {8{in1_s}});
        end
        next_drive = next_drive & ~ovl_latch & ~thr_latch;
    end

    // All eight channels share one drive path; the low-side or high-side wiring of
    // channels two to seven is external and does not change the logic.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            channel_on <= 8'h00;
        end else begin
            channel_on <= next_drive;
        end
    end

    // The probe is only sourced into channels that are off, so it never fights the drive.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            open_load_probe_current <= 8'h00;
        end else begin
            open_load_probe_current <= probe_ctrl & ~next_drive & {8{!idle_s}};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            failsafe_d <= 1'b1; // The empty sync looks like fail-safe just after reset.
        end else begin
            failsafe_d <= failsafe;
        end
    end

    // APB: the setup cycle registers the answer, so access takes exactly one cycle.
    assign apb_setup = psel && !penable;
    assign apb_write = psel && penable && pready && pwrite;
    assign chan_view = {thr_latch, ovl_latch, output_monitor_bits, channel_on};
    assign irq_clear = (apb_write && paddr == `OSC_APB_CLEAR) ? pwdata[`OSC_IRQ_BITS-1:0] : 3'h0;

    always_comb begin
        irq_event = 3'h0;
        irq_event[`OSC_IRQ_FRAME] = rx_valid;
        irq_event[`OSC_IRQ_FAULT] = |(ovl_new & ~ovl_latch) || |(tmp_s & ~thr_latch);
        irq_event[`OSC_IRQ_FAILSAFE] = failsafe && !failsafe_d;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= apb_setup;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
            if (apb_setup) begin
                case (paddr)
                    `OSC_APB_STATUS: prdata <= {29'h00000000, irq_status};
                    `OSC_APB_CLEAR: prdata <= 32'h00000000;
                    `OSC_APB_ENABLE: prdata <= {29'h00000000, irq_enable};
                    `OSC_APB_CHANNEL: prdata <= chan_view;
                    `OSC_APB_CONFIG: prdata <= {probe_ctrl, map1, map0, out_ctrl};
                    default: pslverr <= 1'b1;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_enable <= 3'h0;
        end else if (apb_write && paddr == `OSC_APB_ENABLE) begin
            irq_enable <= pwdata[`OSC_IRQ_BITS-1:0];
        end
    end

    // New events beat a clear written in the same cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status <= 3'h0;
            irq <= 1'b0;
        end else begin
            irq_status <= (irq_status & ~irq_clear) | irq_event;
            irq <= |(irq_status & irq_enable);
        end
    end

    property p_failsafe_route;
        @(posedge pclk) disable iff (!presetn)
        (failsafe && !idle_s) |=> channel_on[`OSC_FS_CH_A] ==
            ($past(in0_s) && !$past(ovl_latch[`OSC_FS_CH_A]) && !$past(thr_latch[`OSC_FS_CH_A]));
    endproperty
    a_failsafe_route: assert property (p_failsafe_route) else $error("fail-safe input zero lost");
    property p_failsafe_only;
        @(posedge pclk) disable iff (!presetn)
        failsafe |=> (channel_on & ~`OSC_FS_MASK) == 8'h00;
    endproperty
    a_failsafe_only: assert property (p_failsafe_only) else $error("mapping used in fail-safe");
    property p_idle_off;
        @(posedge pclk) disable iff (!presetn)
        idle_s |=> channel_on == 8'h00 && open_load_probe_current == 8'h00;
    endproperty
    a_idle_off: assert property (p_idle_off) else $error("channel on in idle mode");
    property p_map_zero;
        @(posedge pclk) disable iff (!presetn)
        (!failsafe && !idle_s && in0_s && (map0 & ~ovl_latch & ~thr_latch) != 8'h00)
            |=> (channel_on & $past(map0 & ~ovl_latch & ~thr_latch)) ==
            $past(map0 & ~ovl_latch & ~thr_latch);
    endproperty
    a_map_zero: assert property (p_map_zero) else $error("mapped channel not driven");
    property p_overload_latch;
        @(posedge pclk) disable iff (!presetn)
        ovl_new != 8'h00 |=> (ovl_latch & $past(ovl_new)) == $past(ovl_new) ##1
            (channel_on & $past(ovl_new, 2)) == 8'h00;
    endproperty
    a_overload_latch: assert property (p_overload_latch) else $error("overload not latched off");
    property p_thermal_latch;
        @(posedge pclk) disable iff (!presetn)
        tmp_s != 8'h00 |=> (thr_latch & $past(tmp_s)) == $past(tmp_s) ##1
            (channel_on & $past(tmp_s, 2)) == 8'h00;
    endproperty
    a_thermal_latch: assert property (p_thermal_latch) else $error("thermal fault not latched");
    property p_latch_holds;
        @(posedge pclk) disable iff (!presetn)
        (thr_latch != 8'h00 && spi_clear == 8'h00) |=> (thr_latch & $past(thr_latch)) ==
            $past(thr_latch);
    endproperty
    a_latch_holds: assert property (p_latch_holds) else $error("latched diagnosis lost");
    property p_probe_gated;
        @(posedge pclk) disable iff (!presetn)
        ##1 (open_load_probe_current & ~$past(probe_ctrl)) == 8'h00 &&
            (open_load_probe_current & channel_on) == 8'h00;
    endproperty
    a_probe_gated: assert property (p_probe_gated) else $error("probe current not requested");
    property p_restart_clears;
        @(posedge pclk) disable iff (!presetn)
        restart != 8'h00 |=> (ovl_latch & $past(restart) & ~$past(ovl_new)) == 8'h00;
    endproperty
    a_restart_clears: assert property (p_restart_clears) else $error("restart did not unlatch");
endmodule : osc_switch_ctrl

// ==== tb/osc_mcu_model.sv ====
// Behavioural serial bus controller that frames commands for the switch block.
`timescale 1ns/1ps
module osc_mcu_model (
    output logic sclk,
    output logic chip_select_n,
    output logic serial_in,
    input wire logic serial_out,
    input wire logic serial_out_oe
);
    logic line_level;
    logic last_level;
    // A released line shows the inverse of its last level so a stale bit can never pass.
    assign line_level = serial_out_oe ? serial_out : ~last_level;
    always @(serial_out or serial_out_oe) if (serial_out_oe) last_level = serial_out;
    initial begin
        sclk = 1'b0;
        chip_select_n = 1'b1;
        serial_in = 1'b0;
        last_level = 1'b0;
    end
    task automatic xfer(input logic [31:0] word, input int nbits, output logic [31:0] answer);
        answer = 32'h00000000;
        // Keep every pin change clear of the block's sampling edge.
        #5;
        chip_select_n = 1'b0;
        #300;
        for (int i = nbits - 1; i >= 0; i--) begin
            serial_in = word[i];
            #100 sclk = 1'b1;
            answer = {answer[30:0], line_level};
            #100 sclk = 1'b0;
        end
        #100 chip_select_n = 1'b1;
        serial_in = 1'b0;
        #300;
    endtask : xfer
endmodule : osc_mcu_model

// ==== tb/test_octal_switch_channel_control.sv ====
// Self-checking bench for the octal switch channel control block.
`timescale 1ns/1ps
module test_octal_switch_channel_control;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata, rd, ans;
    logic pready, pslverr, irq, sclk, chip_select_n, serial_in, serial_out, serial_out_oe, err;
    logic supply_present = 1'b1, idle_select = 1'b0;
    logic direct_input_zero = 1'b0, direct_input_one = 1'b0;
    logic [7:0] overload_detect = 8'h00, overtemp_detect = 8'h00, open_load_sense = 8'h00;
    logic [7:0] channel_on, open_load_probe_current;
    int err_total = 0, n_compared = 0, cycles = 0;

    always #12.5 pclk = ~pclk;

    // A short restart count keeps the fail-safe retry visible within a few dozen cycles.
    osc_switch_ctrl #(.RESTART_CYCLES(20)) u_dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .sclk(sclk),
        .chip_select_n(chip_select_n), .serial_in(serial_in), .serial_out(serial_out),
        .serial_out_oe(serial_out_oe), .supply_present(supply_present),
        .idle_select(idle_select), .direct_input_zero(direct_input_zero),
        .direct_input_one(direct_input_one), .overload_detect(overload_detect),
        .overtemp_detect(overtemp_detect), .open_load_sense(open_load_sense),
        .channel_on(channel_on), .open_load_probe_current(open_load_probe_current));

    osc_mcu_model u_mcu (.sclk(sclk), .chip_select_n(chip_select_n), .serial_in(serial_in),
        .serial_out(serial_out), .serial_out_oe(serial_out_oe));

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask : cyc

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    function automatic logic [31:0] cmd(input logic [2:0] a, input logic [7:0] d);
        return {16'h0000, 1'b1, a, 4'h0, d};
    endfunction : cmd

    task automatic spi(input logic [31:0] w, input int n);
        u_mcu.xfer(w, n, ans);
        cyc(12);
    endtask : spi

    // Bits are supply, idle, input zero, input one.
    task automatic pins(input logic [3:0] p);
        @(posedge pclk);
        {supply_present, idle_select, direct_input_zero, direct_input_one} <= p;
        cyc(6);
    endtask : pins

    task automatic fault(input logic [7:0] ovl, input logic [7:0] tmp);
        @(posedge pclk);
        overload_detect <= ovl;
        overtemp_detect <= tmp;
        cyc(4);
        overload_detect <= 8'h00;
        overtemp_detect <= 8'h00;
        cyc(3);
    endtask : fault

    task automatic done(input string nm);
        $display("test %s finished, mismatches so far %0d", nm, err_total);
    endtask : done

    task automatic close_out;
        $display("comparisons %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : close_out

    always @(posedge pclk) begin
        cycles++;
        if (cycles == 10000) begin
            err_total++;
            close_out();
        end
    end

    initial begin
        cyc(10);
        presetn <= 1'b1;
        cyc(2);
        chk("drive", channel_on, 8'h00);
        chk("oe", serial_out_oe, 1'b0);
        apb(1'b0, 12'h010, 32'h0);
        chk("config", rd, 32'h00080400);
        apb(1'b0, 12'h000, 32'h0);
        chk("status", rd, 32'h00000000);
        done("reset");
        pins(4'hA);
        chk("drive", channel_on, 8'h04);
        pins(4'hB);
        chk("drive", channel_on, 8'h0C);
        spi(cmd(3'h1, 8'hF0), 16);
        chk("drive", channel_on, 8'hF8);
        chk("oe", serial_out_oe, 1'b0);
        spi(cmd(3'h2, 8'h03), 16);
        chk("drive", channel_on, 8'hF3);
        apb(1'b0, 12'h010, 32'h0);
        chk("config", rd, 32'h0003F000);
        done("mapping");
        pins(4'hF);
        chk("drive", channel_on, 8'h00);
        pins(4'h3);
        chk("drive", channel_on, 8'h0C);
        spi(cmd(3'h0, 8'hFF), 16);
        fault(8'h04, 8'h00);
        chk("drive", channel_on, 8'h08);
        cyc(30);
        chk("drive", channel_on, 8'h0C);
        pins(4'h1);
        chk("drive", channel_on, 8'h08);
        pins(4'h8);
        chk("drive", channel_on, 8'h00);
        done("failsafe");
        spi(cmd(3'h0, 8'h21), 16);
        fault(8'h01, 8'h00);
        cyc(30);
        chk("drive", channel_on, 8'h20);
        fault(8'h00, 8'h20);
        chk("drive", channel_on, 8'h00);
        apb(1'b0, 12'h00C, 32'h0);
        chk("channel", rd, 32'h20010000);
        apb(1'b0, 12'h000, 32'h0);
        chk("status", rd, 32'h00000007);
        spi(32'h0, 16);
        chk("answer", ans, 32'h00002100);
        spi(cmd(3'h4, 8'h21), 16);
        chk("drive", channel_on, 8'h21);
        done("faults");
        spi(cmd(3'h0, 8'h00), 16);
        spi(cmd(3'h3, 8'h80), 16);
        chk("probe", open_load_probe_current, 8'h80);
        @(posedge pclk);
        open_load_sense <= 8'h80;
        cyc(6);
        spi(32'h0, 16);
        chk("answer", ans, 32'h00000080);
        spi(cmd(3'h3, 8'h00), 16);
        chk("probe", open_load_probe_current, 8'h00);
        spi(32'h00A58042, 24);
        chk("answer", ans[23:8], 16'h0080);
        chk("passed", ans[7:0], 8'hA5);
        chk("drive", channel_on, 8'h42);
        done("probe and chain");
        apb(1'b1, 12'h008, 32'h1);
        apb(1'b0, 12'h008, 32'h0);
        chk("enable", rd, 32'h00000001);
        apb(1'b1, 12'h004, 32'h7);
        cyc(3);
        chk("irq", irq, 1'b0);
        spi(cmd(3'h0, 8'h42), 16);
        chk("irq", irq, 1'b1);
        apb(1'b0, 12'h000, 32'h0);
        chk("status", rd[0], 1'b1);
        apb(1'b1, 12'h004, 32'h1);
        cyc(3);
        chk("irq", irq, 1'b0);
        apb(1'b1, 12'h008, 32'h0);
        spi(cmd(3'h0, 8'h42), 16);
        chk("irq", irq, 1'b0);
        apb(1'b0, 12'h020, 32'h0);
        chk("slverr", err, 1'b1);
        chk("rdata", rd, 32'h00000000);
        apb(1'b1, 12'h010, 32'hFFFFFFFF);
        apb(1'b0, 12'h010, 32'h0);
        chk("config", rd, 32'h0003F042);
        done("registers");
        close_out();
    end
endmodule : test_octal_switch_channel_control
